// file: rtl/ocb_pkg.sv
// Shared constants for the output clocking and offset register block
package ocb_pkg;
    // Serial frame layout
    localparam int          FRAME_BITS     = 32;
    localparam int          HEADER_BITS    = 12;
    localparam logic [11:0] FRAME_HEADER   = 12'h001;
    localparam int          ADDR_MSB       = 19;
    localparam int          ADDR_LSB       = 16;
    localparam logic [3:0]  ADDR_CONFIG    = 4'h1;
    localparam logic [3:0]  ADDR_OFFSET    = 4'h2;
    // Output configuration field positions
    localparam int          CFG_PHASE_BIT  = 11;
    localparam int          CFG_DDRN_BIT   = 10;
    localparam int          CFG_EDGE_BIT   = 8;
    // Offset correction field positions
    localparam int          OFS_MAG_MSB    = 15;
    localparam int          OFS_MAG_LSB    = 8;
    localparam int          OFS_SIGN_BIT   = 7;
    // Reset values
    localparam logic        RST_PHASE      = 1'b1;
    localparam logic        RST_DDRN       = 1'b1;
    localparam logic        RST_EDGE       = 1'b0;
    localparam logic [7:0]  RST_OFS_MAG    = 8'h00;
    localparam logic        RST_OFS_SIGN   = 1'b0;
    // Output cell timing: one strobe period is four clk cycles
    localparam logic [1:0]  PHASE_LAUNCH_A = 2'h0;
    localparam logic [1:0]  PHASE_LAUNCH_B = 2'h2;
    localparam logic [1:0]  PHASE_MID_A    = 2'h1;
    localparam logic [1:0]  PHASE_MID_B    = 2'h2;
    // Serial receiver states
    typedef enum logic [1:0] {
        OCB_IDLE  = 2'b01,
        OCB_SHIFT = 2'b10
    } ocb_rx_state_t;
endpackage

// file: rtl/ocb_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a group of asynchronous levels
module ocb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;   // Metastable stage, read only below

    ////////////////////////////////////////////////////////////////////////
    // Both stages clear to zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule // ocb_sync

// file: rtl/ocb_output_clocking.sv
`timescale 1ns/100ps
module ocb_output_clocking
    import ocb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       serialClk,       // Serial clock pin
    input  wire logic       serialSelect_n,  // Serial select pin
    input  wire logic       serialData,      // Serial data pin
    input  wire logic       extendedMode,    // Extended control mode pin
    input  wire logic       launchEdgePin,   // Output edge pin
    input  wire logic [7:0] sampleWord,      // Word from converter core
    output logic            sampleTake,      // Word consumed this cycle
    output logic [7:0]      outData,         // Output data bus
    output logic            dataReadyStrobe, // Data ready strobe
    output logic [7:0]      offsetMagnitude, // Offset to analog core
    output logic            offsetNegative   // Offset sign to analog core
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [4:0] pinSync;          // Synchronised pin levels
    logic       sclkPrev_reg;     // Previous serial clock level
    logic       sclkSync;         // Serial clock, synchronised
    logic       selSync_n;        // Select, synchronised
    logic       dataSync;         // Serial data, synchronised
    logic       extSync;          // Extended mode, synchronised
    logic       edgePinSync;      // Edge pin, synchronised
    logic       sclkRise;         // Serial clock rising edge

    ocb_sync #(
        .WIDTH (5)
    ) u_pin_sync (
        .clk     (clk),
        .reset   (reset),
        .asyncIn ({serialClk, serialSelect_n, serialData,
                   extendedMode, launchEdgePin}),
        .syncOut (pinSync)
    );

    assign sclkSync    = pinSync[4];
    assign selSync_n   = pinSync[3];
    assign dataSync    = pinSync[2];
    assign extSync     = pinSync[1];
    assign edgePinSync = pinSync[0];
    assign sclkRise    = sclkSync & ~sclkPrev_reg;

    // Edge detector history, fed from the second stage only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclkPrev_reg <= 1'b0;
        end else begin
            sclkPrev_reg <= sclkSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial frame receiver
    ocb_rx_state_t rxState_reg;   // Receiver state
    ocb_rx_state_t rxState_next;  // Next receiver state
    logic [31:0]   shift_reg;     // Frame shift register
    logic [31:0]   shift_next;    // Shift register with new bit
    logic [5:0]    bitCnt_reg;    // Bits received in frame
    logic [5:0]    bitCnt_next;   // Next bit count
    logic          frameDone;     // Last bit of frame sampled
    logic          headerOk;      // Header pattern matched
    logic [3:0]    frameAddr;     // Register address of frame
    logic          writeConfig;   // Config register write strobe
    logic          writeOffset;   // Offset register write strobe

    assign shift_next = {shift_reg[30:0], dataSync};
    assign frameDone  = (rxState_reg == OCB_SHIFT) && sclkRise &&
                        (bitCnt_reg == 6'(FRAME_BITS - 1));
    assign headerOk   = (shift_next[FRAME_BITS-1 -: HEADER_BITS]
                         == FRAME_HEADER);
    assign frameAddr  = shift_next[ADDR_MSB:ADDR_LSB];
    assign writeConfig = frameDone && headerOk && (frameAddr == ADDR_CONFIG);
    assign writeOffset = frameDone && headerOk && (frameAddr == ADDR_OFFSET);

    // Next state: select low arms, each frame restarts the count
    always_comb begin
        rxState_next = rxState_reg;
        bitCnt_next  = bitCnt_reg;
        case (rxState_reg)
            OCB_IDLE: begin
                bitCnt_next = 6'h00;
                if (!selSync_n) begin
                    rxState_next = OCB_SHIFT;
                end
            end
            OCB_SHIFT: begin
                if (selSync_n) begin
                    // Partial frame dropped on deselect
                    rxState_next = OCB_IDLE;
                    bitCnt_next  = 6'h00;
                end else if (frameDone) begin
                    // Back-to-back frames start on the next clock
                    bitCnt_next = 6'h00;
                end else if (sclkRise) begin
                    bitCnt_next = bitCnt_reg + 6'h01;
                end
            end
            default: begin
                rxState_next = OCB_IDLE;
                bitCnt_next  = 6'h00;
            end
        endcase
    end

    // Receiver registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxState_reg <= OCB_IDLE;
            bitCnt_reg  <= 6'h00;
            shift_reg   <= 32'h0000_0000;
        end else begin
            rxState_reg <= rxState_next;
            bitCnt_reg  <= bitCnt_next;
            if ((rxState_reg == OCB_SHIFT) && sclkRise) begin
                shift_reg <= shift_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-only registers; fixed-one bits are not stored
    logic       strobePhase_reg;    // Strobe phase select field
    logic       doubleRateN_reg;    // Double rate select, active low
    logic       launchEdge_reg;     // Output edge field
    logic [7:0] offsetMag_reg;      // Offset magnitude
    logic       offsetSign_reg;     // Offset sign

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobePhase_reg <= RST_PHASE;
            doubleRateN_reg <= RST_DDRN;
            launchEdge_reg  <= RST_EDGE;
            offsetMag_reg   <= RST_OFS_MAG;
            offsetSign_reg  <= RST_OFS_SIGN;
        end else begin
            if (writeConfig) begin
                strobePhase_reg <= shift_next[CFG_PHASE_BIT];
                doubleRateN_reg <= shift_next[CFG_DDRN_BIT];
                launchEdge_reg  <= shift_next[CFG_EDGE_BIT];
            end
            if (writeOffset) begin
                offsetMag_reg  <= shift_next[OFS_MAG_MSB:OFS_MAG_LSB];
                offsetSign_reg <= shift_next[OFS_SIGN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective settings; normal mode uses defaults and the edge pin
    logic effPhase;     // Strobe phase in force
    logic effDdr;       // Double rate in force
    logic effEdge;      // Launch edge in force

    assign effPhase = extSync ? strobePhase_reg : RST_PHASE;
    assign effDdr   = extSync ? ~doubleRateN_reg : ~RST_DDRN;
    assign effEdge  = extSync ? launchEdge_reg : edgePinSync;

    ////////////////////////////////////////////////////////////////////////
    // Output cell timing
    logic [1:0] phaseCnt_reg;   // Position within strobe period
    logic [1:0] phaseCnt_next;  // Next position
    logic       wordLaunch;     // New word goes out next edge
    logic       strobe_next;    // Next strobe level
    logic       strobeDdr0;     // Strobe aligned with data edges
    logic       strobeDdr90;    // Strobe mid data cell
    logic       strobeSdr;      // Single rate strobe

    assign phaseCnt_next = phaseCnt_reg + 2'h1;
    assign wordLaunch = (phaseCnt_next == PHASE_LAUNCH_A) ||
                        (effDdr && (phaseCnt_next == PHASE_LAUNCH_B));
    // Aligned strobe: edges entering positions 0 and 2
    assign strobeDdr0  = ~phaseCnt_next[1];
    // Shifted strobe: edges entering positions 1 and 3
    assign strobeDdr90 = (phaseCnt_next == PHASE_MID_A) ||
                         (phaseCnt_next == PHASE_MID_B);
    assign strobeSdr   = effEdge ? ~phaseCnt_next[1] : phaseCnt_next[1];
    assign strobe_next = effDdr ? (effPhase ? strobeDdr90 : strobeDdr0)
                                : strobeSdr;
    assign sampleTake  = wordLaunch;

    // Strobe and data launched from the same clock edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phaseCnt_reg    <= 2'h3;
            dataReadyStrobe <= 1'b0;
            outData         <= 8'h00;
        end else begin
            phaseCnt_reg    <= phaseCnt_next;
            dataReadyStrobe <= strobe_next;
            if (wordLaunch) begin
                outData <= sampleWord;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Offset to the analog core, zero outside extended mode
    // Sign applied
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            offsetMagnitude <= 8'h00;
            offsetNegative  <= 1'b0;
        end else begin
            offsetMagnitude <= extSync ? offsetMag_reg : RST_OFS_MAG;
            offsetNegative  <= extSync ? offsetSign_reg : RST_OFS_SIGN;
        end
    end
endmodule // ocb_output_clocking

// file: tb/ocb_checker.sv
`timescale 1ns/100ps
// Pin-level watch over launch timing and offset outputs
module ocb_checker (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       serialClk,
    input wire logic       serialSelect_n,
    input wire logic       serialData,
    input wire logic       extendedMode,
    input wire logic       launchEdgePin,
    input wire logic [7:0] sampleWord,
    input wire logic       sampleTake,
    input wire logic [7:0] outData,
    input wire logic       dataReadyStrobe,
    input wire logic [7:0] offsetMagnitude,
    input wire logic       offsetNegative
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    take_data_a: assert property (sampleTake |=>
        outData == $past(sampleWord)) else $error("word not launched");
    hold_data_a: assert property (!sampleTake |=>
        $stable(outData)) else $error("bus moved without a take");
    take_space_a: assert property (sampleTake |=>
        !sampleTake) else $error("takes closer than two cycles");
    // Settled normal mode only, as a mode switch may stretch a level
    norm_sdr_a: assert property ((!extendedMode)[*8] ##0 sampleTake
        |=> (!sampleTake)[*3]) else $error("normal mode not single rate");
    norm_rise_a: assert property ((!extendedMode && launchEdgePin
        && $stable(launchEdgePin))[*8] ##0 sampleTake
        |=> $rose(dataReadyStrobe)) else $error("rising launch missed");
    norm_fall_a: assert property ((!extendedMode && !launchEdgePin
        && $stable(launchEdgePin))[*8] ##0 sampleTake
        |=> $fell(dataReadyStrobe)) else $error("falling launch missed");
    strobe_half_a: assert property ((!extendedMode
        && $stable(launchEdgePin))[*8] ##0 $rose(dataReadyStrobe)
        |=> dataReadyStrobe ##1 !dataReadyStrobe)
        else $error("strobe half period wrong");
    norm_offset_a: assert property ((!extendedMode)[*5] |->
        offsetMagnitude == 8'h00 && !offsetNegative)
        else $error("offset applied in normal mode");
    ofs_hold_a: assert property ((serialSelect_n && extendedMode)[*8]
        |=> $stable(offsetMagnitude) && $stable(offsetNegative))
        else $error("offset moved with no frame");
endmodule // ocb_checker
bind ocb_output_clocking ocb_checker u_ocb_checker (.clk(clk),
    .reset(reset), .serialClk(serialClk), .serialSelect_n(serialSelect_n),
    .serialData(serialData), .extendedMode(extendedMode),
    .launchEdgePin(launchEdgePin), .sampleWord(sampleWord),
    .sampleTake(sampleTake), .outData(outData),
    .dataReadyStrobe(dataReadyStrobe), .offsetMagnitude(offsetMagnitude),
    .offsetNegative(offsetNegative));

// file: tb/ocb_capture_model.sv
`timescale 1ns/100ps
// Far-side capture: takes the bus word on every strobe transition
module ocb_capture_model (
    input  wire logic       clk,
    input  wire logic       strobe,
    input  wire logic [7:0] busData,
    output logic      [7:0] capWord
);
    logic prevStrobe_reg; // Strobe level one cycle back
    // Capture a cycle late, so aligned and mid-cell both settle
    always_ff @(posedge clk) begin
        prevStrobe_reg <= strobe;
        if (strobe != prevStrobe_reg) begin
            capWord <= busData;
        end
    end
endmodule // ocb_capture_model

// file: tb/output_clocking_offset_config_bench.sv
`timescale 1ns/100ps
module output_clocking_offset_config_bench
    import ocb_pkg::*;
;
    logic       clk = 1'b0, reset = 1'b1, serialClk = 1'b0;
    logic       serialSelect_n = 1'b1, serialData = 1'b1;
    logic       extendedMode = 1'b1, launchEdgePin = 1'b0;
    logic [7:0] sampleWord = 8'h00;
    logic       sampleTake, dataReadyStrobe, offsetNegative;
    logic [7:0] outData, offsetMagnitude, capWord;
    int         err_total = 0, cmp_count = 0;
    always #25 clk = ~clk;
    // Core word moves every cycle so a stale launch shows
    always @(posedge clk) sampleWord <= #1 sampleWord + 8'h13;
    ocb_output_clocking u_ocb_output_clocking (.clk(clk), .reset(reset),
        .serialClk(serialClk), .serialSelect_n(serialSelect_n),
        .serialData(serialData), .extendedMode(extendedMode),
        .launchEdgePin(launchEdgePin), .sampleWord(sampleWord),
        .sampleTake(sampleTake), .outData(outData),
        .dataReadyStrobe(dataReadyStrobe),
        .offsetMagnitude(offsetMagnitude), .offsetNegative(offsetNegative));
    ocb_capture_model u_ocb_capture_model (.clk(clk),
        .strobe(dataReadyStrobe), .busData(outData), .capWord(capWord));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [15:0] cfg(input logic p, n, e);
        cfg = 16'h82ff;
        cfg[CFG_PHASE_BIT] = p;
        cfg[CFG_DDRN_BIT] = n;
        cfg[CFG_EDGE_BIT] = e;
    endfunction
    // Serial clock idles low; released data shows the inverse bit
    task automatic send(input logic [11:0] h, input logic [3:0] a,
                        input logic [15:0] d);
        logic [31:0] f;
        f = {h, a, d};
        serialSelect_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            serialData = f[i];
            tick(4);
            serialClk = 1'b1;
            tick(4);
            serialClk = 1'b0;
        end
        tick(4);
        serialSelect_n = 1'b1;
        serialData = ~f[0];
        tick(12);
    endtask
    // Launch from strobe level s0: new level s1, spacing gap cycles
    task automatic look(input logic s0, input logic s1, input int gap);
        logic [7:0] w;
        int n;
        n = 0;
        while (!(sampleTake === 1'b1 && dataReadyStrobe === s0)
               && n < 40) begin
            tick(1);
            n++;
        end
        // Launch never seen within the limit counts as a mismatch
        chk(9'(n >= 40), 9'h000);
        #2 w = sampleWord;
        tick(1);
        chk({1'b0, outData}, {1'b0, w});
        chk({8'h00, dataReadyStrobe}, {8'h00, s1});
        n = 0;
        while (sampleTake !== 1'b1 && n < 9) begin
            tick(1);
            n++;
        end
        chk(9'(n), 9'(gap - 1));
        tick(1);
        chk({1'b0, capWord}, {1'b0, w});
    endtask
    task automatic t_cfg();
        look(1'b1, 1'b0, 4);
        chk({offsetNegative, offsetMagnitude}, 9'h000);
        // Phase set to mid-cell in single rate: must have no effect
        send(12'h001, 4'h1, cfg(1'b1, 1'b1, 1'b1));
        look(1'b0, 1'b1, 4);
        send(12'h001, 4'h1, cfg(1'b0, 1'b0, 1'b1));
        look(1'b0, 1'b1, 2);
        send(12'h001, 4'h1, cfg(1'b1, 1'b0, 1'b1));
        look(1'b0, 1'b0, 2);
    endtask
    task automatic t_ofs();
        send(12'h001, 4'h2, {8'ha5, 1'b1, 7'h7f});
        chk({offsetNegative, offsetMagnitude}, 9'h1a5);
        send(12'h002, 4'h2, 16'h00ff);
        send(12'h001, 4'h3, 16'h00ff);
        chk({offsetNegative, offsetMagnitude}, 9'h1a5);
        send(12'h001, 4'h2, {8'hff, 1'b0, 7'h7f});
        chk({offsetNegative, offsetMagnitude}, 9'h0ff);
    endtask
    // Normal mode: registers still hold double rate, pin rules
    task automatic t_norm();
        extendedMode = 1'b0;
        launchEdgePin = 1'b1;
        tick(12);
        look(1'b0, 1'b1, 4);
        chk({offsetNegative, offsetMagnitude}, 9'h000);
        launchEdgePin = 1'b0;
        tick(12);
        look(1'b1, 1'b0, 4);
        extendedMode = 1'b1;
        tick(12);
        chk({offsetNegative, offsetMagnitude}, 9'h0ff);
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        tick(6);
        reset = 1'b0;
        tick(2);
        t_cfg();
        t_ofs();
        t_norm();
        end_sim();
    end
    // Whole run needs about 2000 cycles
    initial begin
        #250000;
        err_total++;
        end_sim();
    end
endmodule // output_clocking_offset_config_bench
